/* File: logic/flash_ecc_consts.vh */
`ifndef FLASH_ECC_CONSTS_VH
`define FLASH_ECC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define REG_FAULT_DATA      8'h00
`define REG_STATUS          8'h04
`define REG_CONTROL         8'h08
`define REG_ADDR_W          8

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define STAT_PENDING_BIT    0
`define STAT_RESET_SEEN_BIT 1
`define CTRL_CAPTURE_EN_BIT 0
`define CTRL_RESET          32'h0000_0001
`define FAULT_DATA_RESET    32'h0000_0000

// ----------------------------------------------------------------------------
// Flash access kinds
// ----------------------------------------------------------------------------
`define ACC_READ            2'h0
`define ACC_PROGRAM         2'h1
`define ACC_ERASE           2'h2

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: logic/ecc_hazard_tracker.v */
`timescale 1ns/10ps
`default_nettype none
`include "flash_ecc_consts.vh"

module ecc_hazard_tracker (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        acc_valid,
    input  wire [1:0]  acc_kind,
    input  wire        acc_dbl_err,
    output reg         pending,
    output reg         fire
);

    // ------------------------------------------------------------------------
    // Pending hazard and reset request
    // ------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pending <= 1'b0;
            fire    <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (acc_valid) begin
                case (acc_kind)
                    `ACC_READ: begin
                        pending <= acc_dbl_err;
                    end
                    `ACC_PROGRAM: begin
                        fire    <= pending;
                        pending <= 1'b0;
                    end
                    `ACC_ERASE: begin
                        // Erase is harmless and the hazard survives it
                        pending <= pending;
                    end
                    default: begin
                        pending <= pending;
                    end
                endcase
            end
        end
    end

endmodule // ecc_hazard_tracker

`default_nettype wire

/* File: logic/flash_ecc_error_tracking.v */
// Contract
// - Program after double-bit error raises functional reset
// - Clean read clears pending hazard
// - Erase never raises the reset
// - Capture bus data of last enabled event
// - Fault data stored byte-reversed; software swaps
`timescale 1ns/10ps
`default_nettype none
`include "flash_ecc_consts.vh"

module flash_ecc_error_tracking (
    input  wire        aclk,
    input  wire        aresetn,
    // Flash access observation, same clock domain
    input  wire        acc_valid,
    input  wire [1:0]  acc_kind,
    input  wire        acc_dbl_err,
    input  wire        acc_ecc_event,
    input  wire [31:0] acc_rdata,
    output reg         func_reset_req,
    output reg         hazard_pending,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function [31:0] swap_bytes;
        input [31:0] w;
        begin
            swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `REG_FAULT_DATA) || (a == `REG_STATUS) ||
                     (a == `REG_CONTROL);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Hazard tracking
    // ------------------------------------------------------------------------
    wire pending;
    wire fire;

    ecc_hazard_tracker u_tracker (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .acc_valid   (acc_valid),
        .acc_kind    (acc_kind),
        .acc_dbl_err (acc_dbl_err),
        .pending     (pending),
        .fire        (fire)
    );

    // Reset value of the control word; only its enable bit is kept
    localparam [31:0] ctrl_init = `CTRL_RESET;

    reg        capture_en;
    reg [31:0] fault_data;
    reg        reset_seen;
    reg        clr_seen;

    always @(posedge aclk) begin
        if (!aresetn) begin
            func_reset_req <= 1'b0;
            hazard_pending <= 1'b0;
        end else begin
            func_reset_req <= fire;
            hazard_pending <= pending;
        end
    end

    // Only events qualified by the enable update the capture register, so the
    // value always belongs to the last event software asked to keep
    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_data <= `FAULT_DATA_RESET;
        end else if (acc_valid && acc_ecc_event && capture_en) begin
            fault_data <= swap_bytes(acc_rdata);
        end
    end

    // Sticky record of a requested reset; set wins over a clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            reset_seen <= 1'b0;
        end else if (fire) begin
            reset_seen <= 1'b1;
        end else if (clr_seen) begin
            reset_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------------
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write = aw_held && w_held && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            capture_en    <= ctrl_init[`CTRL_CAPTURE_EN_BIT];
            clr_seen      <= 1'b0;
        end else begin
            clr_seen      <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_addr == `REG_CONTROL && w_strb[0]) begin
                    capture_en <= w_data[`CTRL_CAPTURE_EN_BIT];
                end
                // Write one to clear the sticky reset record
                if (aw_addr == `REG_STATUS && w_strb[0]) begin
                    clr_seen <= w_data[`STAT_RESET_SEEN_BIT];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------------
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (s_axi_araddr)
            `REG_FAULT_DATA: next_rdata = fault_data;
            `REG_STATUS: begin
                next_rdata[`STAT_PENDING_BIT]    = pending;
                next_rdata[`STAT_RESET_SEEN_BIT] = reset_seen;
            end
            `REG_CONTROL: next_rdata[`CTRL_CAPTURE_EN_BIT] = capture_en;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // flash_ecc_error_tracking

`default_nettype wire

/* File: dv/flash_client_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_client_model (
    input  wire logic        aclk,
    output logic             acc_valid,
    output logic [1:0]       acc_kind,
    output logic             acc_dbl_err,
    output logic             acc_ecc_event,
    output logic [31:0]      acc_rdata
);
    initial begin
        acc_valid = 0; acc_kind = 0; acc_dbl_err = 0; acc_ecc_event = 0; acc_rdata = 0;
    end
    // Kind, error and data lines flip and acc_ecc_event drops with acc_valid, so stale values cannot pass
    task access(input logic [1:0] k, input logic e, input logic [31:0] d);
        @(posedge aclk);
        acc_valid <= 1; acc_kind <= k; acc_dbl_err <= e; acc_ecc_event <= e; acc_rdata <= d;
        @(posedge aclk);
        acc_valid <= 0; acc_kind <= ~k; acc_dbl_err <= ~e; acc_ecc_event <= 0; acc_rdata <= ~d;
    endtask
endmodule // flash_client_model
`default_nettype wire

/* File: dv/flash_ecc_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "flash_ecc_consts.vh"
module flash_ecc_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       acc_valid,
    input wire logic [1:0] acc_kind,
    input wire logic       acc_dbl_err,
    input wire logic       func_reset_req,
    input wire logic       hazard_pending,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // The pin lags one cycle, so an access in the previous cycle hides the state
    sequence prog_armed;
        acc_valid && acc_kind == `ACC_PROGRAM && hazard_pending && !$past(acc_valid);
    endsequence
    sequence rd_seen;
        acc_valid && acc_kind == `ACC_READ;
    endsequence
    prog_reset_a: assert property (prog_armed |-> ##2 func_reset_req)
        else $error("no reset request after program with pending hazard");
    dbl_arm_a: assert property (rd_seen ##0 acc_dbl_err |-> ##2 hazard_pending)
        else $error("double error read did not arm hazard");
    clean_read_a: assert property (rd_seen ##0 !acc_dbl_err |-> ##2 !hazard_pending)
        else $error("clean read left hazard pending");
    erase_quiet_a: assert property (acc_valid && acc_kind == `ACC_ERASE
        |-> ##2 !func_reset_req && $stable(hazard_pending))
        else $error("erase changed hazard or raised reset");
    read_quiet_a: assert property (rd_seen |-> ##2 !func_reset_req)
        else $error("read raised reset request");
    reset_cause_a: assert property (func_reset_req
        |-> $past(acc_valid, 2) && $past(acc_kind, 2) == `ACC_PROGRAM)
        else $error("reset request without program access");
    reset_clear_a: assert property ($rose(aresetn) |-> !hazard_pending ##1 !hazard_pending)
        else $error("hazard survived reset");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
endmodule // flash_ecc_checker
bind flash_ecc_error_tracking flash_ecc_checker flash_ecc_checker_i (.aclk, .aresetn,
    .acc_valid, .acc_kind, .acc_dbl_err, .func_reset_req, .hazard_pending, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

/* File: dv/tb_flash_ecc_error_tracking.sv */
`timescale 1ns/10ps
`default_nettype none
`include "flash_ecc_consts.vh"
module tb_flash_ecc_error_tracking;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0]  aw = 0, ar = 0;
    logic [3:0]  ws = 4'hF;
    logic [31:0] wd = 0, rd;
    logic [1:0]  rs;
    wire  [1:0]  ak, br, rr;
    wire         av, ad, ae, frr, hp, awr, wr, bv, arr, rv;
    wire  [31:0] adat, rdat;
    integer bad_count = 0, compares = 0, fires = 0;
    always #20 aclk = ~aclk;
    always @(posedge aclk) if (frr === 1'b1) fires <= fires + 1;
    flash_client_model flash_client_model_i (.aclk(aclk), .acc_valid(av), .acc_kind(ak),
        .acc_dbl_err(ad), .acc_ecc_event(ae), .acc_rdata(adat));
    flash_ecc_error_tracking flash_ecc_error_tracking_i (.aclk(aclk), .aresetn(aresetn),
        .acc_valid(av), .acc_kind(ak), .acc_dbl_err(ad), .acc_ecc_event(ae), .acc_rdata(adat),
        .func_reset_req(frr), .hazard_pending(hp), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        aw <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        // No cycle count is assumed; only the watchdog ends a stuck wait
        while (bv !== 1'b1) begin
            @(posedge aclk);
            if (awr === 1'b1) begin
                awv <= 0;
                aw <= ~a;
            end
            if (wr === 1'b1) begin
                wv <= 0;
                wd <= ~d;
            end
        end
        bry <= 0; rs = br;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge aclk);
        ar <= a; arv <= 1; rry <= 1;
        while (rv !== 1'b1) begin
            @(posedge aclk);
            if (arr === 1'b1) begin
                arv <= 0;
                ar <= ~a;
            end
        end
        rry <= 0; rd = rdat; rs = rr;
    endtask
    task acc(input logic [1:0] k, input logic e, input logic [31:0] d);
        flash_client_model_i.access(k, e, d);
        repeat (3) @(posedge aclk);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        check("pending", hp, 0);
        acc(`ACC_READ, 1, 32'hAABBCCDD);
        // A long gap must not disarm the hazard
        repeat (20) @(posedge aclk);
        acc(`ACC_PROGRAM, 0, 0);
        check("resets", fires, 1);
        acc(`ACC_READ, 1, 32'h11223344);
        acc(`ACC_READ, 0, 32'h5A5A5A5A);
        acc(`ACC_PROGRAM, 0, 0);
        check("resets", fires, 1);
        acc(`ACC_READ, 1, 32'h55667788);
        acc(`ACC_ERASE, 0, 0);
        check("resets", fires, 1);
        acc(`ACC_PROGRAM, 0, 0);
        check("resets", fires, 2);
        rd_reg(`REG_FAULT_DATA);
        check("fault data", rd, 32'h88776655);
        wr_reg(`REG_CONTROL, 0);
        check("write resp", rs, `RESP_OKAY);
        acc(`ACC_READ, 1, 32'h0BADF00D);
        rd_reg(`REG_FAULT_DATA);
        check("fault data", rd, 32'h88776655);
        rd_reg(`REG_STATUS);
        check("pending bit", rd[`STAT_PENDING_BIT], 1);
        check("reset record", rd[`STAT_RESET_SEEN_BIT], 1);
        wr_reg(`REG_STATUS, 32'h0000_0002);
        check("write resp", rs, `RESP_OKAY);
        rd_reg(`REG_STATUS);
        check("reset record", rd[`STAT_RESET_SEEN_BIT], 0);
        check("pending bit", rd[`STAT_PENDING_BIT], 1);
        rd_reg(8'h0C);
        check("unmapped resp", rs, `RESP_SLVERR);
        check("unmapped data", rd, 32'h0000_0000);
        // Write with every strobe low must leave the control word alone
        ws <= 4'h0;
        wr_reg(`REG_CONTROL, 32'h0000_0001);
        ws <= 4'hF;
        rd_reg(`REG_CONTROL);
        check("control", rd, 32'h0000_0000);
        wr_reg(`REG_FAULT_DATA, 32'hFFFFFFFF);
        rd_reg(`REG_FAULT_DATA);
        check("fault data", rd, 32'h88776655);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        check("pending", hp, 0);
        acc(`ACC_PROGRAM, 0, 0);
        check("resets", fires, 2);
        rd_reg(`REG_FAULT_DATA);
        check("fault data", rd, `FAULT_DATA_RESET);
        rd_reg(`REG_CONTROL);
        check("control", rd, `CTRL_RESET);
        test_done;
    end
    initial begin
        #100000;
        bad_count++;
        test_done;
    end
endmodule // tb_flash_ecc_error_tracking
`default_nettype wire
